// >>> bench/oslc_jtag_host.sv
`timescale 1ns/1ps
module oslc_jtag_host (
   // Clock
   input wire logic         pclk,
   // OTP access toward the tile
   output logic             req,
   output logic             write,
   output logic [10:0]      addr,
   output logic [31:0]      wdata,
   input  wire logic        ack,
   input  wire logic        denied,
   input  wire logic [31:0] rdata
);
   initial begin
      req   = 1'b0;
      write = 1'b0;
      addr  = 11'h7ff;
      wdata = 32'hffff_ffff;
   end
   // Released fields show their inverse so a stale value never looks current
   task automatic access(input logic w, input logic [10:0] a, input logic [31:0] d,
                         output logic [1:0] res, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge pclk);
      req   <= 1'b1;
      write <= w;
      addr  <= a;
      wdata <= d;
      do begin
         @(posedge pclk);
         n++;
      end while (ack !== 1'b1 && denied !== 1'b1 && n < 50);
      res = {ack, denied};
      rd  = rdata;
      req   <= 1'b0;
      write <= ~w;
      addr  <= ~a;
      wdata <= ~d;
   endtask : access
endmodule : oslc_jtag_host

// >>> bench/oslc_otp_security_asserts.sv
`timescale 1ns/1ps
module oslc_otp_security_asserts (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   // Access gates
   input wire logic        jtag_tile_req,
   input wire logic        jtag_tile_grant,
   input wire logic        jtag_otp_req,
   input wire logic        jtag_otp_ack,
   input wire logic        jtag_otp_denied,
   input wire logic [9:0]  jtag_userid_ext,
   input wire logic        link_req,
   input wire logic        link_grant,
   input wire logic        link_refused,
   input wire logic        debug_req_n,
   input wire logic        debug_halt,
   // Boot
   input wire logic        sram_we,
   input wire logic [10:0] sram_addr,
   input wire logic        proc_run,
   input wire logic        proc_boot_otp,
   input wire logic        otp_redundancy_en
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_tile_needs_req: assert property (jtag_tile_grant |-> $past(jtag_tile_req))
      else $error("tile grant without a request");
   a_link_answered: assert property (link_req |=> link_grant ^ link_refused)
      else $error("link request not answered by exactly one outcome");
   a_boot_fixed: assert property (proc_run |-> $stable(proc_boot_otp))
      else $error("boot source moved while running");
   a_redundancy_fixed: assert property (proc_run |-> $stable(otp_redundancy_en))
      else $error("redundancy enable moved while running");
   a_otp_ack_timing: assert property (jtag_otp_ack |-> $past(jtag_otp_req, 2) && !jtag_otp_denied)
      else $error("otp ack without a request two cycles before");
   a_otp_deny_cause: assert property (jtag_otp_denied |-> $past(jtag_otp_req))
      else $error("otp denial without a request");
   a_debug_latency: assert property ($rose(debug_halt) |-> !$past(debug_req_n, 3))
      else $error("halt without the debug pin low three cycles before");
   a_userid_fixed: assert property (proc_run |-> $stable(jtag_userid_ext))
      else $error("user id extension moved while running");
   a_copy_in_order: assert property (sram_we && sram_addr != oslc_pkg::LAST_ROW |=>
      sram_we && sram_addr == $past(sram_addr) + 11'h001)
      else $error("copy skipped or repeated a row");
   a_copy_ends_run: assert property (sram_we && sram_addr == oslc_pkg::LAST_ROW |-> ##[0:1] proc_run)
      else $error("processor not started after the last row");
   a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("register access not completed after one wait state");
endmodule : oslc_otp_security_asserts

bind oslc_otp_security oslc_otp_security_asserts i_oslc_otp_security_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .jtag_tile_req(jtag_tile_req), .jtag_tile_grant(jtag_tile_grant), .jtag_otp_req(jtag_otp_req),
   .jtag_otp_ack(jtag_otp_ack), .jtag_otp_denied(jtag_otp_denied), .jtag_userid_ext(jtag_userid_ext),
   .link_req(link_req), .link_grant(link_grant), .link_refused(link_refused), .debug_req_n(debug_req_n),
   .debug_halt(debug_halt), .sram_we(sram_we), .sram_addr(sram_addr), .proc_run(proc_run),
   .proc_boot_otp(proc_boot_otp), .otp_redundancy_en(otp_redundancy_en));

// >>> bench/oslc_otp_security_test.sv
`timescale 1ns/1ps
module oslc_otp_security_test;
   localparam logic [31:0] SEC_A = 32'h2a85_0100;
   localparam logic [31:0] SEC_B = 32'h2a85_71a3;
   localparam logic [31:0] ROW_A = 32'h1234_5678;
   localparam logic [31:0] ROW_B = 32'h00c0_ffee;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sram_we, proc_run;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, jtag_otp_wdata, jtag_otp_rdata, sram_wdata, boot_word;
   logic        jtag_tile_req, jtag_tile_grant, jtag_otp_req, jtag_otp_write, jtag_otp_ack, jtag_otp_denied;
   logic [10:0] jtag_otp_addr, sram_addr;
   logic [9:0]  jtag_userid_ext;
   logic        link_req, link_grant, link_refused, debug_req_n, debug_halt, proc_boot_otp, otp_redundancy_en;
   int          failures, total_checks, copied;

   oslc_otp_security i_oslc_otp_security (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .jtag_tile_req(jtag_tile_req),
      .jtag_tile_grant(jtag_tile_grant), .jtag_otp_req(jtag_otp_req), .jtag_otp_write(jtag_otp_write),
      .jtag_otp_addr(jtag_otp_addr), .jtag_otp_wdata(jtag_otp_wdata), .jtag_otp_ack(jtag_otp_ack),
      .jtag_otp_denied(jtag_otp_denied), .jtag_otp_rdata(jtag_otp_rdata), .jtag_userid_ext(jtag_userid_ext),
      .link_req(link_req), .link_grant(link_grant), .link_refused(link_refused), .debug_req_n(debug_req_n),
      .debug_halt(debug_halt), .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
      .proc_run(proc_run), .proc_boot_otp(proc_boot_otp), .otp_redundancy_en(otp_redundancy_en));
   oslc_jtag_host i_oslc_jtag_host (
      .pclk(pclk), .req(jtag_otp_req), .write(jtag_otp_write), .addr(jtag_otp_addr),
      .wdata(jtag_otp_wdata), .ack(jtag_otp_ack), .denied(jtag_otp_denied), .rdata(jtag_otp_rdata));

   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (sram_we === 1'b1) begin
         copied <= copied + 1;
         if (sram_addr === 11'h000) boot_word <= sram_wdata;
      end
   end

   task automatic finish_test();
      if (failures == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd  = prdata;
      err = pslverr;
      if (n >= 20) begin
         failures++;
         finish_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      logic err;
      apb(1'b0, a, 32'h0000_0000, v, err);
   endtask : rd_reg
   task automatic op(input logic [10:0] row, input logic [31:0] d, input logic [31:0] ctrl);
      wr(oslc_pkg::REG_ADDR, {21'h00_0000, row});
      wr(oslc_pkg::REG_DATA, d);
      wr(oslc_pkg::REG_CTRL, ctrl);
   endtask : op
   task automatic row_of(input logic [10:0] row, output logic [31:0] v);
      op(row, 32'h0000_0000, 32'h0000_0002);
      rd_reg(oslc_pkg::REG_RDATA, v);
   endtask : row_of
   task automatic boot();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      copied = 0;
      presetn <= 1'b1;
   endtask : boot
   task automatic wait_run();
      int n;
      n = 0;
      while (proc_run !== 1'b1 && n < 3000) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 3000) begin
         failures++;
         finish_test();
      end
      // Let the last row's write be counted
      @(negedge pclk);
   endtask : wait_run
   // Order of expectation bits: tile grant, link grant, link refused, halt
   task automatic gates(input logic [3:0] exp);
      @(posedge pclk);
      jtag_tile_req <= 1'b1;
      link_req      <= 1'b1;
      debug_req_n   <= 1'b0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("tile grant", 32'(exp[3]), 32'(jtag_tile_grant));
      chk("link grant", 32'(exp[2]), 32'(link_grant));
      chk("link refused", 32'(exp[1]), 32'(link_refused));
      chk("debug halt", 32'(exp[0]), 32'(debug_halt));
      @(posedge pclk);
      jtag_tile_req <= 1'b0;
      link_req      <= 1'b0;
      debug_req_n   <= 1'b1;
   endtask : gates

   task automatic t_first_burn();
      logic [31:0] v;
      boot();
      wait_run();
      op(11'h000, ROW_A, 32'h0000_0001);
      op(11'h200, ROW_B, 32'h0000_0001);
      op(11'h000, SEC_A, 32'h0000_0005);
      row_of(11'h200, v);
      chk("programmed row", ROW_B, v);
   endtask : t_first_burn
   task automatic t_copy_and_boot();
      logic [31:0] v;
      boot();
      wr(oslc_pkg::REG_CTRL, 32'h0000_0001);
      wait_run();
      chk("copied rows", 32'h0000_0800, 32'(copied));
      chk("boot row", ROW_A, boot_word);
      rd_reg(oslc_pkg::REG_STATUS, v);
      chk("status after early op", 32'h0000_000b, v);
      rd_reg(oslc_pkg::REG_SECURITY, v);
      chk("security word", SEC_A, v);
      chk("user id", 32'(SEC_A[31:22]), 32'(jtag_userid_ext));
      chk("boot select", 32'h0000_0000, 32'(proc_boot_otp));
      chk("redundancy", 32'h0000_0000, 32'(otp_redundancy_en));
      wr(oslc_pkg::REG_STATUS, 32'h0000_0008);
   endtask : t_copy_and_boot
   task automatic t_sector_lock();
      logic [31:0] v;
      op(11'h000, 32'hffff_0000, 32'h0000_0001);
      rd_reg(oslc_pkg::REG_STATUS, v);
      chk("status locked sector", 32'h0000_000b, v);
      row_of(11'h000, v);
      chk("locked row", ROW_A, v);
      op(11'h200, 32'h0100_0000, 32'h0000_0001);
      row_of(11'h200, v);
      chk("open row", ROW_B | 32'h0100_0000, v);
      wr(oslc_pkg::REG_STATUS, 32'h0000_000c);
   endtask : t_sector_lock
   task automatic t_open_paths();
      logic [1:0]  res;
      logic [31:0] v;
      logic        err;
      i_oslc_jtag_host.access(1'b0, 11'h000, 32'h0000_0000, res, v);
      chk("jtag read answer", 32'h0000_0002, 32'(res));
      chk("jtag read data", ROW_A, v);
      i_oslc_jtag_host.access(1'b1, 11'h000, 32'h0000_00ff, res, v);
      chk("jtag locked write", 32'h0000_0001, 32'(res));
      gates(4'b1101);
      apb(1'b0, 8'h40, 32'h0000_0000, v, err);
      chk("unmapped error", 32'h0000_0001, 32'(err));
      chk("unmapped data", 32'h0000_0000, v);
      op(11'h000, SEC_B, 32'h0000_0005);
      rd_reg(oslc_pkg::REG_SECURITY, v);
      chk("security before reset", SEC_A, v);
   endtask : t_open_paths
   task automatic t_secure_island();
      logic [1:0]  res;
      logic [31:0] v;
      boot();
      wait_run();
      rd_reg(oslc_pkg::REG_SECURITY, v);
      chk("armed security word", SEC_B, v);
      chk("boot select", 32'h0000_0001, 32'(proc_boot_otp));
      chk("redundancy", 32'h0000_0001, 32'(otp_redundancy_en));
      chk("boot row", ROW_A, boot_word);
      gates(4'b0010);
      i_oslc_jtag_host.access(1'b0, 11'h200, 32'h0000_0000, res, v);
      chk("jtag otp denied", 32'h0000_0001, 32'(res));
      op(11'h200, 32'h0000_0001, 32'h0000_0001);
      rd_reg(oslc_pkg::REG_STATUS, v);
      chk("status master lock row", 32'h0000_000b, v);
      wr(oslc_pkg::REG_STATUS, 32'h0000_0008);
      op(11'h000, 32'hffff_ffff, 32'h0000_0005);
      rd_reg(oslc_pkg::REG_STATUS, v);
      chk("status master lock word", 32'h0000_000b, v);
      row_of(11'h200, v);
      chk("row under master lock", ROW_B | 32'h0100_0000, v);
      boot();
      wait_run();
      rd_reg(oslc_pkg::REG_SECURITY, v);
      chk("word under master lock", SEC_B, v);
   endtask : t_secure_island

   initial begin
      pclk          = 1'b0;
      presetn       = 1'b0;
      psel          = 1'b0;
      penable       = 1'b0;
      pwrite        = 1'b0;
      paddr         = 8'h00;
      pwdata        = 32'h0000_0000;
      jtag_tile_req = 1'b0;
      link_req      = 1'b0;
      debug_req_n   = 1'b1;
      failures      = 0;
      total_checks  = 0;
      copied        = 0;
      t_first_burn();
      t_copy_and_boot();
      t_sector_lock();
      t_open_paths();
      t_secure_island();
      finish_test();
   end
endmodule : oslc_otp_security_test

// >>> shared/oslc_otp_if.sv
`timescale 1ns/1ps
interface oslc_otp_if;
   logic [10:0] addr;
   logic        sec_sel;
   logic        prog;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] sec_rdata;
   logic        redundancy_en;

   modport ctrl  (output addr, sec_sel, prog, wdata, redundancy_en, input rdata, sec_rdata);
   modport array (input addr, sec_sel, prog, wdata, redundancy_en, output rdata, sec_rdata);
endinterface : oslc_otp_if

// >>> shared/oslc_pkg.sv
// Behaviour
// - Security bit 0 blocks JTAG access to tile state and memory.
// - Security bit 1 refuses other tiles reaching processor state via switch.
// - Security bit 5 forces boot from OTP start, ignoring boot pins.
// - Security bit 7 switches on the OTP redundant rows.
// - Bits 8 to 11 lock programming of sectors 0 to 3.
// - Security bit 12 refuses all programming, sectors and security word.
// - Security bit 13 denies JTAG read and write of OTP.
// - Security bit 14 makes the device ignore the debug request pin.
// - Bits 21 to 15 are a software readable general purpose field.
// - Bits 31 to 22 extend the reported JTAG user identification code.
// - OTP holds 8 KB: four sectors of 512 rows, 32 bits each.
// - Security word loads from OTP at power-up before features act.
// - Remaining OTP contents copy to SRAM and run first.
// - Forced secure boot fetches the image from OTP address zero.
package oslc_pkg;
   // OTP geometry
   localparam int unsigned ROWS       = 2048;
   localparam int unsigned ROW_W      = 32;
   localparam int unsigned ADDR_W     = 11;
   localparam int unsigned SECTOR_MSB = 10;
   localparam int unsigned SECTOR_LSB = 9;
   localparam logic [10:0] LAST_ROW   = 11'h7ff;
   localparam logic [10:0] FIRST_ROW  = 11'h000;

   // Security word fields
   localparam int unsigned SEC_NO_JTAG    = 0;
   localparam int unsigned SEC_NO_LINK    = 1;
   localparam int unsigned SEC_BOOT_OTP   = 5;
   localparam int unsigned SEC_REDUNDANT  = 7;
   localparam int unsigned SEC_LOCK0      = 8;
   localparam int unsigned SEC_LOCK3      = 11;
   localparam int unsigned SEC_MASTER     = 12;
   localparam int unsigned SEC_NO_JTAGOTP = 13;
   localparam int unsigned SEC_NO_DEBUG   = 14;
   localparam int unsigned SEC_GP_LSB     = 15;
   localparam int unsigned SEC_GP_MSB     = 21;
   localparam int unsigned SEC_UID_LSB    = 22;
   localparam int unsigned SEC_UID_MSB    = 31;

   // APB register byte addresses
   localparam logic [7:0] REG_SECURITY = 8'h00;
   localparam logic [7:0] REG_ADDR     = 8'h04;
   localparam logic [7:0] REG_DATA     = 8'h08;
   localparam logic [7:0] REG_CTRL     = 8'h0c;
   localparam logic [7:0] REG_STATUS   = 8'h10;
   localparam logic [7:0] REG_RDATA    = 8'h14;

   // Control port bits
   localparam int unsigned CTRL_PROG = 0;
   localparam int unsigned CTRL_READ = 1;
   localparam int unsigned CTRL_SEC  = 2;

   // Status bits
   localparam int unsigned ST_LOADED  = 0;
   localparam int unsigned ST_BOOTED  = 1;
   localparam int unsigned ST_DONE    = 2;
   localparam int unsigned ST_REFUSED = 3;
   localparam int unsigned ST_BUSY    = 4;

   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      OSLC_LOAD = 2'b00,
      OSLC_COPY = 2'b01,
      OSLC_IDLE = 2'b11,
      OSLC_OP   = 2'b10
   } oslc_state_t;
endpackage : oslc_pkg

// >>> verilog/oslc_otp_array.sv
`timescale 1ns/1ps
module oslc_otp_array (
   // Clock
   input wire logic  pclk,
   // Array port
   oslc_otp_if.array otp
);
   typedef struct packed {
      logic [oslc_pkg::ROWS-1:0][oslc_pkg::ROW_W-1:0] rows;
      logic [oslc_pkg::ROW_W-1:0]                     sec;
   } oslc_mem_t;

   oslc_mem_t q = '0;
   oslc_mem_t next_q;

   // Fuses start clear; programming only sets bits
   always_comb begin
      next_q = q;
      if (otp.prog) begin
         if (otp.sec_sel) begin
            next_q.sec = q.sec | otp.wdata;
         end else begin
            next_q.rows[otp.addr] = q.rows[otp.addr] | otp.wdata;
         end
      end
   end

   // Non-volatile: survives reset
   always_ff @(posedge pclk) begin
      q <= next_q;
   end

   assign otp.rdata     = q.rows[otp.addr];
   assign otp.sec_rdata = q.sec;
endmodule : oslc_otp_array

// >>> verilog/oslc_otp_security.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module oslc_otp_security (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // JTAG tile access
   input  wire logic        jtag_tile_req,
   output logic             jtag_tile_grant,
   // JTAG OTP access, request held until ack or denied
   input  wire logic        jtag_otp_req,
   input  wire logic        jtag_otp_write,
   input  wire logic [10:0] jtag_otp_addr,
   input  wire logic [31:0] jtag_otp_wdata,
   output logic             jtag_otp_ack,
   output logic             jtag_otp_denied,
   output logic [31:0]      jtag_otp_rdata,
   output logic [9:0]       jtag_userid_ext,
   // Switch access from other tiles
   input  wire logic        link_req,
   output logic             link_grant,
   output logic             link_refused,
   // Debug request pin
   input  wire logic        debug_req_n,
   output logic             debug_halt,
   // Boot and SRAM copy
   output logic             sram_we,
   output logic [10:0]      sram_addr,
   output logic [31:0]      sram_wdata,
   output logic             proc_run,
   output logic             proc_boot_otp,
   output logic             otp_redundancy_en
);
   typedef struct packed {
      oslc_pkg::oslc_state_t state;
      logic [10:0]           copy_idx;
      logic [31:0]           sec;
      logic                  loaded;
      logic                  booted;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      logic [15:0]           otp_addr;
      logic [31:0]           otp_data;
      logic                  ctrl_sec;
      logic [31:0]           rdata;
      logic                  done;
      logic                  refused;
      logic [10:0]           op_addr;
      logic                  op_sec;
      logic                  op_write;
      logic                  op_jtag;
      logic [31:0]           op_data;
      logic                  sram_we;
      logic [10:0]           sram_addr;
      logic [31:0]           sram_wdata;
      logic                  proc_run;
      logic                  boot_otp;
      logic                  jtag_tile_grant;
      logic                  link_grant;
      logic                  link_refused;
      logic                  dbg_s1;
      logic                  dbg_s2;
      logic                  debug_halt;
      logic                  jtag_otp_ack;
      logic                  jtag_otp_denied;
      logic [31:0]           jtag_otp_rdata;
      logic                  redundancy_en;
      logic [9:0]            userid_ext;
   } oslc_ctrl_t;

   oslc_ctrl_t q;
   oslc_ctrl_t next_q;
   oslc_otp_if otp ();

   logic        access;
   logic        mapped;
   logic [31:0] rd_mux;
   logic [31:0] status;
   logic        apb_cmd;
   logic        apb_prog;
   logic [1:0]  apb_sector;
   logic [3:0]  sector_locks;
   logic        apb_locked;
   logic        jtag_locked;

   oslc_otp_array i_oslc_otp_array (
      .pclk (pclk),
      .otp  (otp)
   );

   // Array access comes from registered state only
   always_comb begin
      otp.sec_sel       = 1'b0;
      otp.prog          = 1'b0;
      otp.wdata         = q.op_data;
      otp.addr          = q.op_addr;
      otp.redundancy_en = q.redundancy_en;
      if (q.state == oslc_pkg::OSLC_COPY) begin
         otp.addr = q.copy_idx;
      end else if (q.state == oslc_pkg::OSLC_OP) begin
         otp.sec_sel = q.op_sec;
         otp.prog    = q.op_write;
      end
   end

   assign access       = psel & penable;
   assign sector_locks = q.sec[oslc_pkg::SEC_LOCK3:oslc_pkg::SEC_LOCK0];
   assign apb_sector   = q.otp_addr[oslc_pkg::SECTOR_MSB:oslc_pkg::SECTOR_LSB];
   assign apb_prog     = pwdata[oslc_pkg::CTRL_PROG];
   assign apb_cmd      = access & q.pready & pwrite & (paddr == oslc_pkg::REG_CTRL)
                         & (pwdata[oslc_pkg::CTRL_PROG] | pwdata[oslc_pkg::CTRL_READ]);
   // Master lock covers the security word too; sector locks only rows
   assign apb_locked   = q.sec[oslc_pkg::SEC_MASTER]
                         | (~pwdata[oslc_pkg::CTRL_SEC] & sector_locks[apb_sector]);
   assign jtag_locked  = q.sec[oslc_pkg::SEC_NO_JTAGOTP]
                         | (jtag_otp_write & (q.sec[oslc_pkg::SEC_MASTER]
                         | sector_locks[jtag_otp_addr[oslc_pkg::SECTOR_MSB:oslc_pkg::SECTOR_LSB]]));

   always_comb begin
      status = oslc_pkg::ZERO_WORD;
      status[oslc_pkg::ST_LOADED]  = q.loaded;
      status[oslc_pkg::ST_BOOTED]  = q.booted;
      status[oslc_pkg::ST_DONE]    = q.done;
      status[oslc_pkg::ST_REFUSED] = q.refused;
      status[oslc_pkg::ST_BUSY]    = (q.state != oslc_pkg::OSLC_IDLE);
   end

   // Read data and address decode
   always_comb begin
      mapped = 1'b1;
      rd_mux = oslc_pkg::ZERO_WORD;
      case (paddr)
         oslc_pkg::REG_SECURITY: rd_mux = q.sec;
         oslc_pkg::REG_ADDR:     rd_mux = {16'h0000, q.otp_addr};
         oslc_pkg::REG_DATA:     rd_mux = q.otp_data;
         oslc_pkg::REG_CTRL:     rd_mux[oslc_pkg::CTRL_SEC] = q.ctrl_sec;
         oslc_pkg::REG_STATUS:   rd_mux = status;
         oslc_pkg::REG_RDATA:    rd_mux = q.rdata;
         default:                mapped = 1'b0;
      endcase
   end

   always_comb begin
      next_q = q;
      next_q.sram_we         = 1'b0;
      next_q.jtag_otp_ack    = 1'b0;
      next_q.jtag_otp_denied = 1'b0;

      // APB: one wait state, write acts at the completing edge
      if (access && !q.pready) begin
         next_q.pready  = 1'b1;
         next_q.pslverr = ~mapped;
         next_q.prdata  = rd_mux;
      end else if (access && q.pready) begin
         next_q.pready  = 1'b0;
         next_q.pslverr = 1'b0;
         if (pwrite) begin
            case (paddr)
               oslc_pkg::REG_ADDR: next_q.otp_addr = pwdata[15:0];
               oslc_pkg::REG_DATA: next_q.otp_data = pwdata;
               oslc_pkg::REG_CTRL: next_q.ctrl_sec = pwdata[oslc_pkg::CTRL_SEC];
               oslc_pkg::REG_STATUS: begin
                  if (pwdata[oslc_pkg::ST_DONE]) begin
                     next_q.done = 1'b0;
                  end
                  if (pwdata[oslc_pkg::ST_REFUSED]) begin
                     next_q.refused = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end else begin
         next_q.pready  = 1'b0;
         next_q.pslverr = 1'b0;
      end

      // Sequencer; flag sets follow the clears above so a set wins
      case (q.state)
         oslc_pkg::OSLC_LOAD: begin
            next_q.sec           = otp.sec_rdata;
            next_q.loaded        = 1'b1;
            next_q.boot_otp      = otp.sec_rdata[oslc_pkg::SEC_BOOT_OTP];
            next_q.redundancy_en = otp.sec_rdata[oslc_pkg::SEC_REDUNDANT];
            next_q.userid_ext    = otp.sec_rdata[oslc_pkg::SEC_UID_MSB:oslc_pkg::SEC_UID_LSB];
            next_q.copy_idx      = oslc_pkg::FIRST_ROW;
            next_q.state         = oslc_pkg::OSLC_COPY;
         end
         oslc_pkg::OSLC_COPY: begin
            // Image lands at SRAM word 0, the boot entry point
            next_q.sram_we    = 1'b1;
            next_q.sram_addr  = q.copy_idx;
            next_q.sram_wdata = otp.rdata;
            if (q.copy_idx == oslc_pkg::LAST_ROW) begin
               next_q.booted   = 1'b1;
               next_q.proc_run = 1'b1;
               next_q.state    = oslc_pkg::OSLC_IDLE;
            end else begin
               next_q.copy_idx = q.copy_idx + 11'h001;
            end
         end
         oslc_pkg::OSLC_IDLE: begin
            if (apb_cmd) begin
               next_q.op_addr  = q.otp_addr[10:0];
               next_q.op_data  = q.otp_data;
               next_q.op_sec   = pwdata[oslc_pkg::CTRL_SEC];
               next_q.op_write = apb_prog;
               next_q.op_jtag  = 1'b0;
               if (apb_prog && apb_locked) begin
                  next_q.refused = 1'b1;
               end else begin
                  next_q.state = oslc_pkg::OSLC_OP;
               end
            end else if (jtag_otp_req && !q.jtag_otp_ack && !q.jtag_otp_denied) begin
               next_q.op_addr  = jtag_otp_addr;
               next_q.op_data  = jtag_otp_wdata;
               next_q.op_sec   = 1'b0;
               next_q.op_write = jtag_otp_write;
               next_q.op_jtag  = 1'b1;
               if (jtag_locked) begin
                  next_q.jtag_otp_denied = 1'b1;
               end else begin
                  next_q.state = oslc_pkg::OSLC_OP;
               end
            end
         end
         oslc_pkg::OSLC_OP: begin
            next_q.state = oslc_pkg::OSLC_IDLE;
            if (q.op_jtag) begin
               next_q.jtag_otp_ack   = 1'b1;
               next_q.jtag_otp_rdata = otp.rdata;
            end else begin
               next_q.done = 1'b1;
               if (!q.op_write) begin
                  next_q.rdata = q.op_sec ? otp.sec_rdata : otp.rdata;
               end
            end
         end
         default: begin
            next_q.state = oslc_pkg::OSLC_LOAD;
         end
      endcase
      // A command arriving while busy is refused
      if (apb_cmd && q.state != oslc_pkg::OSLC_IDLE) begin
         next_q.refused = 1'b1;
      end

      // Access gates stay shut until the security word is loaded
      next_q.jtag_tile_grant = q.loaded & ~q.sec[oslc_pkg::SEC_NO_JTAG] & jtag_tile_req;
      next_q.link_grant      = q.loaded & ~q.sec[oslc_pkg::SEC_NO_LINK] & link_req;
      next_q.link_refused    = link_req & ~(q.loaded & ~q.sec[oslc_pkg::SEC_NO_LINK]);
      next_q.dbg_s1          = debug_req_n;
      next_q.dbg_s2          = q.dbg_s1;
      next_q.debug_halt      = q.loaded & ~q.sec[oslc_pkg::SEC_NO_DEBUG] & ~q.dbg_s2;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q        <= '0;
         q.state  <= oslc_pkg::OSLC_LOAD;
         q.dbg_s1 <= 1'b1;
         q.dbg_s2 <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign prdata            = q.prdata;
   assign pready            = q.pready;
   assign pslverr           = q.pslverr;
   assign jtag_tile_grant   = q.jtag_tile_grant;
   assign jtag_otp_ack      = q.jtag_otp_ack;
   assign jtag_otp_denied   = q.jtag_otp_denied;
   assign jtag_otp_rdata    = q.jtag_otp_rdata;
   assign jtag_userid_ext   = q.userid_ext;
   assign link_grant        = q.link_grant;
   assign link_refused      = q.link_refused;
   assign debug_halt        = q.debug_halt;
   assign sram_we           = q.sram_we;
   assign sram_addr         = q.sram_addr;
   assign sram_wdata        = q.sram_wdata;
   assign proc_run          = q.proc_run;
   assign proc_boot_otp     = q.boot_otp;
   assign otp_redundancy_en = q.redundancy_en;
endmodule : oslc_otp_security
